// *** bert_chk.sv ***
// port checker for the tester, lane 0 register shadow kept locally
// assumes it is bound to the tester top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module bert_chk (
   // clock, reset and strobes
   input wire logic        clk, rst_n, reg_wr, reg_rd,
   // address, data, transmit strobes and interrupts
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata, reg_rdata, tx_bit_en, tx_data, bert_irq
);
   logic [7:0] sh_r [16];  // last value written per lane 0 offset
   // shadow follows writes so readback has something to match
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) sh_r <= '{default: 8'h00};
      else if (reg_wr && reg_addr[15:4] == 12'h110) sh_r[reg_addr[3:0]] <= reg_wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   idle_read_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (reg_rd && (reg_addr[15:7] != 9'h022
      || reg_addr[3:0] == 4'h0) |=> reg_rdata == 8'h00) else $error("unmapped read");
   status_top_a: assert property (reg_rd && reg_addr[3:0] == 4'hE |=> !reg_rdata[7])
      else $error("status bit 7 set");
   pattern_read_a: assert property (reg_rd && reg_addr[15:4] == 12'h110
      && reg_addr[3:0] inside {[1:4]} |=> reg_rdata == sh_r[$past(reg_addr[3:0])])
      else $error("pattern byte readback");
   err_ctl_read_a: assert property (reg_rd && reg_addr == 16'h1106 |=> reg_rdata == sh_r[6])
      else $error("error control readback");
   mask_read_a: assert property (reg_rd && reg_addr == 16'h110F
      |=> reg_rdata[6:0] == sh_r[15][6:0]) else $error("mask readback");
   mask_gate_a: assert property (sh_r[15] == 8'h00 && $past(sh_r[15]) == 8'h00
      |-> !bert_irq[0]) else $error("masked interrupt raised");
   tx_hold_a: assert property (!tx_bit_en[0] |=> $stable(tx_data[0]))
      else $error("transmit bit moved unasked");
endmodule : bert_chk
`default_nettype wire

// *** bert_pkg.sv ***
// constants shared by the bit error rate tester and its pattern sources
// assumes byte-wide register access and one bit per enable strobe on each lane
package bert_pkg;

   // port count and address layout
   localparam int          NUM_PORTS     = 8;
   localparam logic [15:0] ADDR_BASE     = 16'h1100;
   localparam logic [15:0] ADDR_PAT0     = 16'h1101;
   localparam logic [15:0] ADDR_PAT1     = 16'h1102;
   localparam logic [15:0] ADDR_PAT2     = 16'h1103;
   localparam logic [15:0] ADDR_PAT3     = 16'h1104;
   localparam logic [15:0] ADDR_TEST_CTL = 16'h1105;
   localparam logic [15:0] ADDR_ERR_CTL  = 16'h1106;
   localparam logic [15:0] ADDR_BITS0    = 16'h1107;
   localparam logic [15:0] ADDR_BITS1    = 16'h1108;
   localparam logic [15:0] ADDR_BITS2    = 16'h1109;
   localparam logic [15:0] ADDR_BITS3    = 16'h110A;
   localparam logic [15:0] ADDR_ERRS0    = 16'h110B;
   localparam logic [15:0] ADDR_ERRS1    = 16'h110C;
   localparam logic [15:0] ADDR_ERRS2    = 16'h110D;
   localparam logic [15:0] ADDR_STATUS   = 16'h110E;
   localparam logic [15:0] ADDR_MASK     = 16'h110F;

   // test control register fields
   localparam int TC_REALIGN  = 0;
   localparam int TC_LATCH    = 1;
   localparam int TC_PAT_LO   = 2;
   localparam int TC_PAT_HI   = 4;
   localparam int TC_RX_INV   = 5;
   localparam int TC_TX_INV   = 6;
   localparam int TC_RESTART  = 7;

   // error insert and length register fields
   localparam int EC_LEN_LO   = 0;
   localparam int EC_LEN_HI   = 3;
   localparam int EC_SINGLE   = 4;
   localparam int EC_RATE_LO  = 5;
   localparam int EC_RATE_HI  = 7;

   // status bit positions
   localparam int ST_SYNC     = 0;
   localparam int ST_LOST     = 1;
   localparam int ST_ZEROS    = 2;
   localparam int ST_ONES     = 3;
   localparam int ST_ERR_WRAP = 4;
   localparam int ST_BIT_WRAP = 5;
   localparam int ST_ERR_SEEN = 6;

   // reset values
   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam logic [19:0] PRBS_SEED  = 20'hF_FFFF;

   // counts in bits
   localparam logic [5:0]  SYNC_MATCH_LAST = 6'h1F;
   localparam logic [5:0]  RUN_BITS        = 6'h20;
   localparam logic [4:0]  REP_LEN_MIN_IDX = 5'h10;

   // pattern select codes
   localparam logic [2:0] PAT_PRBS7  = 3'h0;
   localparam logic [2:0] PAT_PRBS11 = 3'h1;
   localparam logic [2:0] PAT_PRBS15 = 3'h2;
   localparam logic [2:0] PAT_QRSS   = 3'h3;
   localparam logic [2:0] PAT_PRBS9  = 3'h7;

   // bits between automatic errors, minus one, by rate code
   localparam logic [23:0] ERR_GAP_LAST [8] = '{
      24'h00_0000, 24'h00_0009, 24'h00_0063, 24'h00_03E7,
      24'h00_270F, 24'h01_869F, 24'h0F_423F, 24'h98_967F};

   // repetitive style patterns walk the stored word, the rest are shift registers
   function automatic logic pat_is_repeat(input logic [2:0] m);
      return m[2] && (m != PAT_PRBS9);
   endfunction : pat_is_repeat

endpackage : bert_pkg

// *** bit_error_rate_tester.sv ***
// eight-lane bit error rate tester with byte register port
// assumes one transmit and one receive bit per enable strobe, same clock
`timescale 1ns/1ns
`default_nettype none
module bit_error_rate_tester
   import bert_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // transmit data path, one bit per lane
   input  wire logic [7:0]  tx_bit_en,
   output wire logic [7:0]  tx_data,
   // receive data path, one bit per lane
   input  wire logic [7:0]  rx_bit_en,
   input  wire logic [7:0]  rx_data,
   // per-lane interrupt requests
   output wire logic [7:0]  bert_irq
);

   typedef enum logic {SEARCH, LOCKED} sync_state_e;

   logic                         blk_hit;   // address inside the register window
   logic [2:0]                   sel_port;  // lane picked by the address
   logic [15:0]                  loc_addr;  // address folded onto lane zero
   logic [NUM_PORTS-1:0][7:0]    port_rd;   // read data of each lane

   ////////////////////////////////////////////////////////////////////////////
   // address decode shared by all lanes
   assign blk_hit  = (reg_addr[15:7] == ADDR_BASE[15:7]);
   assign sel_port = reg_addr[6:4];
   assign loc_addr = {ADDR_BASE[15:7], 3'h0, reg_addr[3:0]};

   // read data live only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= REG_RESET;
      end else if (reg_rd && blk_hit) begin
         reg_rdata <= port_rd[sel_port];
      end else begin
         // unmapped or idle reads give zero
         reg_rdata <= REG_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one lane per port
   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_lane

      logic [31:0]  pat_r;        // stored repetitive word
      logic [7:0]   tctl_r;       // test control
      logic [7:0]   ectl_r;       // error insert and length control
      logic [6:0]   mask_r;       // interrupt mask
      logic [6:0]   stat_r;       // sticky status
      logic [7:0]   tctl_d_r;     // control delayed for edge detect
      logic         sbe_d_r;      // single inject delayed
      logic         sbe_pend_r;   // single error waiting for a bit
      logic [23:0]  gap_r;        // bits since last automatic error
      logic         tx_q_r;       // transmit bit register
      logic         irq_r;        // interrupt register
      sync_state_e  sync_r;       // checker state
      logic [5:0]   match_r;      // consecutive matches in search
      logic [5:0]   ones_r;       // consecutive ones received
      logic [5:0]   zeros_r;      // consecutive zeros received
      logic [3:0]   cond_d_r;     // conditions of previous cycle
      logic [31:0]  run_bits_r;   // running bit count
      logic [23:0]  run_errs_r;   // running error count
      logic [31:0]  bits_tally_r; // readable bit tally
      logic [23:0]  errs_tally_r; // readable error tally
      logic         wr_sel;       // write aimed at this lane
      logic         rd_sel;       // read aimed at this lane
      logic         realign_rise; // force_realign request edge
      logic         latch_rise;   // count latch edge
      logic         restart_rise; // generator reload edge
      logic         sbe_rise;     // single inject edge
      logic [2:0]   rate;         // automatic error rate code
      logic         rate_hit;     // automatic error due now
      logic         rx_bit;       // received bit after optional invert
      logic         mism;         // received bit differs from expected
      logic         compared;     // bit checked while locked
      logic         bit_wrap;     // bit count wraps this cycle
      logic         err_wrap;     // error count wraps this cycle
      logic [3:0]   cond;         // ones, zeros, searching, locked
      logic [6:0]   ev;           // status set terms
      logic [7:0]   rd_v;         // read data of this lane

      pat_if gen_if ();
      pat_if chk_if ();

      pattern_source u_gen (
         .clk   (clk),
         .rst_n (rst_n),
         .p     (gen_if)
      );

      pattern_source u_chk (
         .clk   (clk),
         .rst_n (rst_n),
         .p     (chk_if)
      );

      assign wr_sel = reg_wr && blk_hit && (sel_port == 3'(g));
      assign rd_sel = reg_rd && blk_hit && (sel_port == 3'(g));

      /////////////////////////////////////////////////////////////////////////
      // software writable registers
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pat_r  <= {4{REG_RESET}};
            tctl_r <= REG_RESET;
            ectl_r <= REG_RESET;
            mask_r <= REG_RESET[6:0];
         end else if (wr_sel) begin
            case (loc_addr)
               ADDR_PAT0:     pat_r[7:0]   <= reg_wdata;
               ADDR_PAT1:     pat_r[15:8]  <= reg_wdata;
               ADDR_PAT2:     pat_r[23:16] <= reg_wdata;
               ADDR_PAT3:     pat_r[31:24] <= reg_wdata;
               ADDR_TEST_CTL: tctl_r       <= reg_wdata;
               ADDR_ERR_CTL:  ectl_r       <= reg_wdata;
               // top mask bit is reserved
               ADDR_MASK:     mask_r       <= reg_wdata[6:0];
               default:       ;
            endcase
         end
      end

      // edge detect: holding a bit high gives only one action
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tctl_d_r <= REG_RESET;
            sbe_d_r  <= 1'b0;
         end else begin
            tctl_d_r <= tctl_r;
            sbe_d_r  <= ectl_r[EC_SINGLE];
         end
      end

      assign realign_rise = tctl_r[TC_REALIGN] && !tctl_d_r[TC_REALIGN];
      assign latch_rise   = tctl_r[TC_LATCH] && !tctl_d_r[TC_LATCH];
      assign restart_rise = tctl_r[TC_RESTART] && !tctl_d_r[TC_RESTART];
      assign sbe_rise     = ectl_r[EC_SINGLE] && !sbe_d_r;

      /////////////////////////////////////////////////////////////////////////
      // transmit generator
      assign gen_if.mode     = tctl_r[TC_PAT_HI:TC_PAT_LO];
      assign gen_if.len_sel  = ectl_r[EC_LEN_HI:EC_LEN_LO];
      assign gen_if.pattern  = pat_r;
      assign gen_if.step     = tx_bit_en[g];
      assign gen_if.feed_en  = 1'b0;
      assign gen_if.feed_bit = 1'b0;
      assign gen_if.restart  = restart_rise;

      assign rate     = ectl_r[EC_RATE_HI:EC_RATE_LO];
      assign rate_hit = (rate != 3'h0) && (gap_r == ERR_GAP_LAST[rate]);

      // count bits between automatic errors; code zero holds at rest
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            gap_r <= 24'h00_0000;
         end else if (rate == 3'h0) begin
            gap_r <= 24'h00_0000;
         end else if (tx_bit_en[g]) begin
            gap_r <= rate_hit ? 24'h00_0000 : gap_r + 24'h00_0001;
         end
      end

      // one pending single error, new request wins over its use
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            sbe_pend_r <= 1'b0;
         end else begin
            sbe_pend_r <= sbe_rise || (sbe_pend_r && !tx_bit_en[g]);
         end
      end

      // outgoing bit with invert and error insertion
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tx_q_r <= 1'b0;
         end else if (tx_bit_en[g]) begin
            tx_q_r <= gen_if.bit_out ^ tctl_r[TC_TX_INV] ^ (rate_hit || sbe_pend_r);
         end
      end

      assign tx_data[g] = tx_q_r;

      /////////////////////////////////////////////////////////////////////////
      // receive checker
      assign rx_bit = rx_data[g] ^ tctl_r[TC_RX_INV];
      assign mism   = (rx_bit != chk_if.bit_out);

      assign chk_if.mode     = tctl_r[TC_PAT_HI:TC_PAT_LO];
      assign chk_if.len_sel  = ectl_r[EC_LEN_HI:EC_LEN_LO];
      assign chk_if.pattern  = pat_r;
      // a repetitive word slips one bit on each miss while searching
      assign chk_if.step     = rx_bit_en[g] && ((sync_r == LOCKED) || !mism ||
                               !pat_is_repeat(chk_if.mode));
      // shift patterns load received bits until lock
      assign chk_if.feed_en  = (sync_r == SEARCH);
      assign chk_if.feed_bit = rx_bit;
      assign chk_if.restart  = realign_rise;

      // search until a full run of matches; only a realign drops lock
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            sync_r  <= SEARCH;
            match_r <= 6'h00;
         end else if (realign_rise) begin
            sync_r  <= SEARCH;
            match_r <= 6'h00;
         end else if (rx_bit_en[g] && (sync_r == SEARCH)) begin
            if (mism) begin
               match_r <= 6'h00;
            end else if (match_r == SYNC_MATCH_LAST) begin
               sync_r  <= LOCKED;
               match_r <= 6'h00;
            end else begin
               match_r <= match_r + 6'h01;
            end
         end
      end

      // runs of ones and zeros, saturating at the full run
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            ones_r  <= 6'h00;
            zeros_r <= 6'h00;
         end else if (rx_bit_en[g]) begin
            ones_r  <= !rx_bit ? 6'h00 : (ones_r == RUN_BITS) ? ones_r : ones_r + 6'h01;
            zeros_r <= rx_bit ? 6'h00 : (zeros_r == RUN_BITS) ? zeros_r : zeros_r + 6'h01;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // running counts and readable tallies
      assign compared = rx_bit_en[g] && (sync_r == LOCKED);
      assign bit_wrap = compared && !latch_rise && (run_bits_r == 32'hFFFF_FFFF);
      assign err_wrap = compared && mism && !latch_rise && (run_errs_r == 24'hFF_FFFF);

      // a bit arriving with the latch edge is dropped from both periods
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            run_bits_r   <= 32'h0000_0000;
            run_errs_r   <= 24'h00_0000;
            bits_tally_r <= 32'h0000_0000;
            errs_tally_r <= 24'h00_0000;
         end else if (latch_rise) begin
            bits_tally_r <= run_bits_r;
            errs_tally_r <= run_errs_r;
            run_bits_r   <= 32'h0000_0000;
            run_errs_r   <= 24'h00_0000;
         end else if (compared) begin
            run_bits_r <= run_bits_r + 32'h0000_0001;
            if (mism) begin
               run_errs_r <= run_errs_r + 24'h00_0001;
            end
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // status: events and both edges of each condition set sticky bits
      assign cond = {ones_r == RUN_BITS, zeros_r == RUN_BITS,
                     sync_r == SEARCH, sync_r == LOCKED};

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            // cleared so the search begun by reset shows as a loss
            cond_d_r <= 4'h0;
         end else begin
            cond_d_r <= cond;
         end
      end

      assign ev[ST_ERR_SEEN] = compared && mism;
      assign ev[ST_BIT_WRAP] = bit_wrap;
      assign ev[ST_ERR_WRAP] = err_wrap;
      assign ev[ST_ONES]     = cond[3] ^ cond_d_r[3];
      assign ev[ST_ZEROS]    = cond[2] ^ cond_d_r[2];
      // a realign while already searching is still a fresh search start
      assign ev[ST_LOST]     = (cond[1] ^ cond_d_r[1]) || realign_rise;
      assign ev[ST_SYNC]     = cond[0] ^ cond_d_r[0];

      // cleared by reading, a new event in the read cycle wins
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            stat_r <= REG_RESET[6:0];
         end else begin
            stat_r <= ((rd_sel && (loc_addr == ADDR_STATUS)) ? 7'h00 : stat_r) | ev;
         end
      end

      // any unmasked sticky bit requests service
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            irq_r <= 1'b0;
         end else begin
            irq_r <= |(stat_r & mask_r);
         end
      end

      assign bert_irq[g] = irq_r;

      /////////////////////////////////////////////////////////////////////////
      // lane read mux
      always_comb begin
         case (loc_addr)
            ADDR_PAT0:     rd_v = pat_r[7:0];
            ADDR_PAT1:     rd_v = pat_r[15:8];
            ADDR_PAT2:     rd_v = pat_r[23:16];
            ADDR_PAT3:     rd_v = pat_r[31:24];
            ADDR_TEST_CTL: rd_v = tctl_r;
            ADDR_ERR_CTL:  rd_v = ectl_r;
            ADDR_BITS0:    rd_v = bits_tally_r[7:0];
            ADDR_BITS1:    rd_v = bits_tally_r[15:8];
            ADDR_BITS2:    rd_v = bits_tally_r[23:16];
            ADDR_BITS3:    rd_v = bits_tally_r[31:24];
            ADDR_ERRS0:    rd_v = errs_tally_r[7:0];
            ADDR_ERRS1:    rd_v = errs_tally_r[15:8];
            ADDR_ERRS2:    rd_v = errs_tally_r[23:16];
            ADDR_STATUS:   rd_v = {1'b0, stat_r};
            ADDR_MASK:     rd_v = {1'b0, mask_r};
            default:       rd_v = REG_RESET;
         endcase
      end

      assign port_rd[g] = rd_v;

   end : g_lane

endmodule : bit_error_rate_tester
`default_nettype wire

// *** bit_error_rate_tester_bench.sv ***
// self-checking bench for the tester, loopback far end on all lanes
// assumes the package constants describe lane 0 addresses
`timescale 1ns/1ns
`default_nettype none
module bit_error_rate_tester_bench;
   import bert_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, tx_data, tx_bit_en, rx_bit_en, rx_data, bert_irq;
   logic [7:0]  d, tc;
   logic [31:0] r, word;
   logic [3:0]  len;
   logic [2:0]  modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6, 3'h4};
   int          n_errors = 0, total_checks = 0, n_bits, e, t;
   bit_error_rate_tester u_bit_error_rate_tester (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_bit_en(tx_bit_en), .tx_data(tx_data), .rx_bit_en(rx_bit_en), .rx_data(rx_data),
      .bert_irq(bert_irq));
   framer_model u_framer_model (.clk(clk), .rst_n(rst_n), .run(run), .tx_data(tx_data),
      .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data), .n_bits(n_bits));
   initial forever #2 clk = ~clk;
   task automatic wr(input logic [15:0] a, input logic [7:0] w);
      {reg_addr, reg_wdata, reg_wr} <= {a, w, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask : rd
   task automatic rdn(input logic [15:0] a, input int n, output logic [31:0] q);
      logic [7:0] b;
      q = '0;
      for (int i = 0; i < n; i++) begin
         rd(a + 16'(i), b);
         q[8*i +: 8] = b;
      end
   endtask : rdn
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   // clear counts, pass n bits, latch, compare bit tally with delivered count
   task automatic burst(input int n);
      int s;
      wr(ADDR_TEST_CTL, tc | 8'h02); wr(ADDR_TEST_CTL, tc);
      s = n_bits;
      run <= 1'b1;
      idle(n);
      run <= 1'b0;
      idle(4);
      wr(ADDR_TEST_CTL, tc | 8'h02); wr(ADDR_TEST_CTL, tc);
      rdn(ADDR_BITS0, 4, r); chk(r, 32'(n_bits - s));
      rdn(ADDR_ERRS0, 3, r);
   endtask : burst
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      #200000 n_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'haa7e));
      idle(4);
      rst_n <= 1'b1;
      idle(1);
      // reset values, read-only and unmapped places on every lane
      for (int n = 0; n < NUM_PORTS; n++) for (int o = 0; o < 16; o++) begin
         wr(ADDR_BASE + 16'(16*n + o), (o == 0 || (o > 6 && o < 15)) ? 8'hFF : 8'h00);
         rd(ADDR_BASE + 16'(16*n + o), d); chk(d, (o == 14) ? 2 : 0);
      end
      word = $urandom;
      len = 4'($urandom);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_PAT0 + 16'(i), word[8*i +: 8]);
         rd(ADDR_PAT0 + 16'(i), d); chk(d, word[8*i +: 8]);
      end
      wr(ADDR_ERR_CTL, {4'h0, len});
      wr(ADDR_MASK, 8'h41);
      // every pattern code: realign, search, lock, interrupt
      foreach (modes[m]) begin
         tc = {3'b000, modes[m], 2'b00};
         wr(ADDR_TEST_CTL, tc | 8'h80); wr(ADDR_TEST_CTL, tc);
         wr(ADDR_TEST_CTL, tc | 8'h01); wr(ADDR_TEST_CTL, tc); idle(3);
         rd(ADDR_STATUS, d); chk(d[1], 1'b1);
         run <= 1'b1;
         idle(1200);
         run <= 1'b0;
         idle(4);
         chk(bert_irq[0], 1'b1);
         rd(ADDR_STATUS, d); chk(d[0], 1'b1);
         idle(2); chk(bert_irq[0], 1'b0);
      end
      // every rate code over a thousand bits
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_ERR_CTL, {3'(k), 1'b0, len});
         burst(1000);
         e = (k == 0) ? 0 : 1000 / 10**k;
         t = (k > 0);
         chk(32'(r + t - e) <= 32'(2 * t), 1'b1);
      end
      rd(ADDR_STATUS, d);
      wr(ADDR_ERR_CTL, {4'h0, len}); wr(ADDR_ERR_CTL, {4'h1, len});
      burst(200); chk(r, 1);
      chk(bert_irq[0], 1'b1);
      rd(ADDR_STATUS, d); chk(d[6], 1'b1);
      // all-ones then all-zeros words through the locked checker
      for (int v = 0; v < 2; v++) begin
         for (int i = 0; i < 4; i++) wr(ADDR_PAT0 + 16'(i), v ? 8'h00 : 8'hFF);
         rd(ADDR_STATUS, d);
         run <= 1'b1;
         idle(40);
         run <= 1'b0;
         idle(4);
         rd(ADDR_STATUS, d);
         chk(d[3 - v], 1'b1);
      end
      wrap_up();
   end
endmodule : bit_error_rate_tester_bench
bind bit_error_rate_tester bert_chk u_bert_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_bit_en(tx_bit_en), .tx_data(tx_data), .bert_irq(bert_irq));
`default_nettype wire

// *** framer_model.sv ***
// far end: hands every lane's transmit bits straight back as receive bits
// assumes the tester clock and a run request from the bench
`timescale 1ns/1ns
`default_nettype none
module framer_model (
   // clock, reset, traffic request
   input  wire logic       clk, rst_n, run,
   // tester side
   input  wire logic [7:0] tx_data,
   output logic      [7:0] tx_bit_en, rx_bit_en, rx_data,
   output int              n_bits  // lane 0 bits handed back
);
   // one bit per cycle each way while running
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) begin
         {tx_bit_en, rx_bit_en} <= 16'h0000;
         n_bits <= 0;
      end else begin
         {tx_bit_en, rx_bit_en} <= {16{run}};
         if (rx_bit_en[0]) n_bits <= n_bits + 1;
      end
   // idle line shows the inverse so stale bits never look valid
   assign rx_data = tx_data ^ ~rx_bit_en;
endmodule : framer_model
`default_nettype wire

// *** pat_if.sv ***
// control and bit link between a tester lane and one pattern source
// assumes one owner drives the controls and the source drives the bit
`timescale 1ns/1ns
`default_nettype none
interface pat_if;
   logic [2:0]  mode;      // pattern select code
   logic [3:0]  len_sel;   // repetitive length code
   logic [31:0] pattern;   // stored repetitive word
   logic        step;      // advance one bit
   logic        feed_en;   // shift in feed_bit instead of feedback
   logic        feed_bit;  // bit shifted in while feed_en
   logic        restart;   // return to start of pattern
   logic        bit_out;   // current pattern bit

   modport ctl (output mode, len_sel, pattern, step, feed_en, feed_bit, restart,
                input  bit_out);
   modport src (input  mode, len_sel, pattern, step, feed_en, feed_bit, restart,
                output bit_out);
endinterface : pat_if
`default_nettype wire

// *** pattern_source.sv ***
// one pattern source: shift register patterns or a stored repetitive word
// assumes the owner advances it once per bit and holds controls steady
`timescale 1ns/1ns
`default_nettype none
module pattern_source
   import bert_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // controls from the lane
   pat_if.src        p
);

   logic [19:0] lfsr_r;    // shift register state
   logic [4:0]  idx_r;     // bit index into the stored word
   logic [4:0]  last_idx;  // final index of the repetitive word
   logic        rep;       // repetitive style in use
   logic        fb;        // shift register feedback

   assign rep      = pat_is_repeat(p.mode);
   // length code counts up from the shortest word, ignored for shift patterns
   assign last_idx = REP_LEN_MIN_IDX + {1'b0, p.len_sel};

   ////////////////////////////////////////////////////////////////////////////
   // feedback taps per polynomial; qrss runs without its zero limit
   always_comb begin
      case (p.mode)
         PAT_PRBS7:  fb = lfsr_r[6] ^ lfsr_r[5];
         PAT_PRBS11: fb = lfsr_r[10] ^ lfsr_r[8];
         PAT_PRBS15: fb = lfsr_r[14] ^ lfsr_r[13];
         PAT_QRSS:   fb = lfsr_r[19] ^ lfsr_r[16];
         PAT_PRBS9:  fb = lfsr_r[8] ^ lfsr_r[4];
         default:    fb = 1'b0;
      endcase
   end

   // least significant pattern bit goes first
   assign p.bit_out = rep ? p.pattern[idx_r] : fb;

   ////////////////////////////////////////////////////////////////////////////
   // state advance
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_r <= PRBS_SEED;
         idx_r  <= 5'h00;
      end else if (p.restart) begin
         lfsr_r <= PRBS_SEED;
         idx_r  <= 5'h00;
      end else if (p.step) begin
         // checker in search feeds received bits to self-align
         lfsr_r <= {lfsr_r[18:0], p.feed_en ? p.feed_bit : fb};
         idx_r  <= (idx_r >= last_idx) ? 5'h00 : idx_r + 5'h01;
      end
   end

endmodule : pattern_source
`default_nettype wire
